/* File: rtl/rtt_timer_trigger.sv */
/*
 * Real-time counter with periodic and match modes, an APB register
 * slave and the slow clock source switch.
 * Assumes two 32 kHz clock pins (internal oscillator and crystal), both
 * asynchronous to pclk, and an APB master on pclk.
 */
`default_nettype none


// ============================================================
// Top module
// ============================================================
module rtt_timer_trigger (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic internal_osc_clk,
  input wire logic external_slow_crystal,
  output logic crystal_power_on,
  output logic [1:0] crystal_drive_tuning,
  output logic periodic_event_flag,
  output logic match_event_flag
);

  // ============================================================
  // Declarations
  // ============================================================
  logic pready_r;              // Access phase answer, one wait state.
  logic pslverr_r;             // Error answer for an unmapped address.
  logic [31:0] prdata_r;       // Read data captured for the answer.
  logic [31:0] rdata_nxt;      // Read mux output.
  logic addr_ok;               // Address hits a mapped register.
  logic wr_en;                 // Write takes effect this edge.
  logic [31:0] match_r;        // Match and load source value.
  logic [15:0] subtick_r;      // Counter clock ticks.
  logic [15:0] two_sec_r;      // Two-second units.
  logic [13:0] day_r;          // Days.
  logic match_en_r;            // Match mode enable.
  logic periodic_en_r;         // Periodic mode enable.
  logic ignore_b0_r;           // Mask bit 0 in the compare.
  logic [2:0] interval_r;      // Periodic interval code.
  logic periodic_flag_r;       // Sticky periodic event.
  logic match_flag_r;          // Sticky match event.
  logic power_on_r;            // Crystal power control.
  logic source_sel_r;          // Requested source, 1 is crystal.
  logic active_src_r;          // Source actually in use.
  logic [1:0] tune_r;          // Crystal drive tuning.
  logic [9:0] switch_cnt_r;    // Cycles since a switch was requested.
  logic [2:0] osc_sync_r;      // Internal oscillator synchroniser and edge.
  logic [2:0] xtal_sync_r;     // Crystal synchroniser and edge.
  logic tick;                  // One-cycle pulse per counter clock rising edge.
  logic tick_d_r;              // Counters have just advanced.
  logic [19:0] period_cnt_r;   // Ticks within the current interval.
  logic [19:0] period_len;     // Interval length in ticks.
  logic load_upper;            // Upper load strobe written as one.
  logic load_lower;            // Lower load strobe written as one.
  logic flag_wr;               // Write to the flag register.
  logic match_hit;             // Counters equal the match value.

  // ============================================================
  // Helper functions
  // ============================================================

  // Write strobe for one register offset.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Compare a counter half with a match half, bit 0 optionally masked.
  function automatic logic half_eq(input logic [15:0] cnt,
                                   input logic [15:0] val,
                                   input logic skip_b0);
    logic [15:0] mask;
    mask = skip_b0 ? 16'hfffe : 16'hffff;
    half_eq = ((cnt & mask) == (val & mask));
  endfunction : half_eq

  // ============================================================
  // APB slave
  // ============================================================

  // The answer comes one cycle into the access phase; a write lands
  // on the same edge that samples pready high.
  assign wr_en = psel & penable & pwrite & pready_r;
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= rtt_pkg::OFS_SLOWCLK);
  assign load_upper = wr_en & hit(paddr, rtt_pkg::OFS_MODE) &
                      pwdata[rtt_pkg::MODE_LOAD_UPPER];
  assign load_lower = wr_en & hit(paddr, rtt_pkg::OFS_MODE) &
                      pwdata[rtt_pkg::MODE_LOAD_LOWER];
  assign flag_wr = wr_en & hit(paddr, rtt_pkg::OFS_FLAG);

  // Read mux; reserved bits and load strobes read as zero.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (paddr)
      rtt_pkg::OFS_MATCH: begin
        rdata_nxt = match_r;
      end
      rtt_pkg::OFS_SUBTICK: begin
        rdata_nxt[15:0] = subtick_r;
      end
      rtt_pkg::OFS_TWO_SEC: begin
        rdata_nxt[15:0] = two_sec_r;
      end
      rtt_pkg::OFS_DAY: begin
        rdata_nxt[13:0] = day_r;
      end
      rtt_pkg::OFS_MODE: begin
        rdata_nxt[rtt_pkg::MODE_MATCH_EN] = match_en_r;
        rdata_nxt[rtt_pkg::MODE_PERIODIC_EN] = periodic_en_r;
        rdata_nxt[rtt_pkg::MODE_IGNORE_B0] = ignore_b0_r;
        rdata_nxt[2:0] = interval_r;
      end
      rtt_pkg::OFS_FLAG: begin
        rdata_nxt[rtt_pkg::FLAG_MATCH] = match_flag_r;
        rdata_nxt[rtt_pkg::FLAG_PERIODIC] = periodic_flag_r;
        // Clear controls self-clear, so they read one only when off.
        rdata_nxt[rtt_pkg::FLAG_MATCH_CLR] = ~match_en_r;
        rdata_nxt[rtt_pkg::FLAG_PERIODIC_CLR] = ~periodic_en_r;
      end
      rtt_pkg::OFS_SLOWCLK: begin
        rdata_nxt[rtt_pkg::SCK_POWER_ON] = power_on_r;
        rdata_nxt[rtt_pkg::SCK_SOURCE_SEL] = source_sel_r;
        rdata_nxt[3:2] = tune_r;
        rdata_nxt[rtt_pkg::SCK_ACTIVE_SRC] = active_src_r;
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  // Answer register: pready pulses for one cycle per access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~addr_ok;
      prdata_r <= (psel & penable & ~pready_r & ~pwrite) ? rdata_nxt :
                  32'h0000_0000;
    end
  end

  // ============================================================
  // Control registers
  // ============================================================

  // Match value, mode bits and slow clock configuration.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_r <= rtt_pkg::MATCH_RESET;
      match_en_r <= 1'b0;
      periodic_en_r <= 1'b0;
      ignore_b0_r <= 1'b0;
      interval_r <= rtt_pkg::MODE_SEL_RESET;
      power_on_r <= 1'b0;
      source_sel_r <= 1'b0;
      tune_r <= rtt_pkg::SCK_TUNE_RESET;
    end else if (wr_en) begin
      if (hit(paddr, rtt_pkg::OFS_MATCH)) begin
        match_r <= pwdata;
      end
      if (hit(paddr, rtt_pkg::OFS_MODE)) begin
        match_en_r <= pwdata[rtt_pkg::MODE_MATCH_EN];
        periodic_en_r <= pwdata[rtt_pkg::MODE_PERIODIC_EN];
        ignore_b0_r <= pwdata[rtt_pkg::MODE_IGNORE_B0];
        interval_r <= pwdata[2:0];
      end
      if (hit(paddr, rtt_pkg::OFS_SLOWCLK)) begin
        // Software powers the crystal before selecting it.
        power_on_r <= pwdata[rtt_pkg::SCK_POWER_ON];
        source_sel_r <= pwdata[rtt_pkg::SCK_SOURCE_SEL];
        tune_r <= pwdata[3:2];
      end
    end
  end

  // ============================================================
  // Slow clock pins and source switch
  // ============================================================

  // Two flops per pin before use; the third flop only feeds the edge
  // detector so the first stage is never read by logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sync_r <= 3'h0;
      xtal_sync_r <= 3'h0;
    end else begin
      osc_sync_r <= {osc_sync_r[1:0], internal_osc_clk};
      xtal_sync_r <= {xtal_sync_r[1:0], external_slow_crystal};
    end
  end

  // Switch only while both clocks are low, so no edge is lost or
  // doubled; if the old clock has died, force it at the time limit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_src_r <= 1'b0;
      switch_cnt_r <= 10'h000;
    end else if (source_sel_r == active_src_r) begin
      switch_cnt_r <= 10'h000;
    end else if ((~osc_sync_r[1] & ~xtal_sync_r[1]) ||
                 (switch_cnt_r == rtt_pkg::SWITCH_LIMIT)) begin
      active_src_r <= source_sel_r;
      switch_cnt_r <= 10'h000;
    end else begin
      switch_cnt_r <= switch_cnt_r + 10'h001;
    end
  end

  // Rising edge of the active source is one counter tick.
  assign tick = active_src_r ? (xtal_sync_r[1] & ~xtal_sync_r[2]) :
                               (osc_sync_r[1] & ~osc_sync_r[2]);

  // ============================================================
  // Time counters
  // ============================================================

  // Sub-tick and two-second counters; a lower load wins over a tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      subtick_r <= rtt_pkg::COUNT_RESET;
      two_sec_r <= rtt_pkg::COUNT_RESET;
    end else if (load_lower) begin
      two_sec_r <= match_r[31:16];
      subtick_r <= match_r[15:0];
    end else if (tick) begin
      subtick_r <= subtick_r + 16'h0001;
      if (subtick_r == 16'hffff) begin
        if (two_sec_r == rtt_pkg::TWO_SEC_PER_DAY - 16'h0001) begin
          two_sec_r <= rtt_pkg::COUNT_RESET;
        end else begin
          two_sec_r <= two_sec_r + 16'h0001;
        end
      end
    end
  end

  // Day counter; an upper load wins over the day roll-over.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      day_r <= rtt_pkg::DAY_RESET;
    end else if (load_upper) begin
      day_r <= match_r[13:0];
    end else if (tick && !load_lower && (subtick_r == 16'hffff) &&
                 (two_sec_r == rtt_pkg::TWO_SEC_PER_DAY - 16'h0001)) begin
      day_r <= day_r + 14'h0001;
    end
  end

  // ============================================================
  // Periodic mode
  // ============================================================

  assign period_len = rtt_pkg::PERIOD_BASE_TICKS << interval_r;

  // Interval counter restarts whenever the mode is off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_cnt_r <= 20'h00000;
    end else if (!periodic_en_r) begin
      period_cnt_r <= 20'h00000;
    end else if (tick) begin
      if (period_cnt_r >= period_len - 20'h00001) begin
        period_cnt_r <= 20'h00000;
      end else begin
        period_cnt_r <= period_cnt_r + 20'h00001;
      end
    end
  end

  // Sticky flag; an interval end in the clear cycle still sets it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periodic_flag_r <= 1'b0;
    end else if (periodic_en_r && tick &&
                 (period_cnt_r >= period_len - 20'h00001)) begin
      periodic_flag_r <= 1'b1;
    end else if (flag_wr && periodic_en_r &&
                 pwdata[rtt_pkg::FLAG_PERIODIC_CLR]) begin
      periodic_flag_r <= 1'b0;
    end
  end

  // ============================================================
  // Match mode
  // ============================================================

  // Compare only just after the counters move, so a clear is not
  // undone for the rest of a tick in which they still match.
  assign match_hit = half_eq(two_sec_r, match_r[31:16], 1'b0) &&
                     half_eq(subtick_r, match_r[15:0], ignore_b0_r);

  // Delayed tick marks the cycle with freshly updated counters.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_d_r <= 1'b0;
    end else begin
      tick_d_r <= tick & ~load_lower;
    end
  end

  // Sticky match flag; set wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_flag_r <= 1'b0;
    end else if (match_en_r && tick_d_r && match_hit) begin
      match_flag_r <= 1'b1;
    end else if (flag_wr && match_en_r &&
                 pwdata[rtt_pkg::FLAG_MATCH_CLR]) begin
      match_flag_r <= 1'b0;
    end
  end

  // ============================================================
  // Outputs
  // ============================================================

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign crystal_power_on = power_on_r;
  assign crystal_drive_tuning = tune_r;
  assign periodic_event_flag = periodic_flag_r;
  assign match_event_flag = match_flag_r;

endmodule : rtt_timer_trigger

`default_nettype wire

/* File: rtl/rtt_pkg.sv */
/*
 * Constants shared by the real-time counter block: register offsets,
 * field positions, reset values and cycle counts.
 * Assumes a 40 MHz APB clock and a nominal 32768 Hz counter clock.
 */
`default_nettype none

// ============================================================
// Package
// ============================================================
package rtt_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFS_MATCH = 8'h00;
  localparam logic [7:0] OFS_SUBTICK = 8'h04;
  localparam logic [7:0] OFS_TWO_SEC = 8'h08;
  localparam logic [7:0] OFS_DAY = 8'h0c;
  localparam logic [7:0] OFS_MODE = 8'h10;
  localparam logic [7:0] OFS_FLAG = 8'h14;
  localparam logic [7:0] OFS_SLOWCLK = 8'h18;

  // Mode control fields.
  localparam int MODE_LOAD_UPPER = 7;
  localparam int MODE_LOAD_LOWER = 6;
  localparam int MODE_MATCH_EN = 5;
  localparam int MODE_PERIODIC_EN = 4;
  localparam int MODE_IGNORE_B0 = 3;
  localparam int MODE_SEL_LSB = 0;
  localparam logic [2:0] MODE_SEL_RESET = 3'h2;

  // Flag and control fields.
  localparam int FLAG_MATCH = 7;
  localparam int FLAG_PERIODIC = 6;
  localparam int FLAG_MATCH_CLR = 5;
  localparam int FLAG_PERIODIC_CLR = 4;

  // Slow clock configuration fields.
  localparam int SCK_POWER_ON = 0;
  localparam int SCK_SOURCE_SEL = 1;
  localparam int SCK_TUNE_LSB = 2;
  localparam int SCK_ACTIVE_SRC = 7;
  localparam logic [1:0] SCK_TUNE_RESET = 2'h1;

  // Value after reset of the match register and the counters.
  localparam logic [31:0] MATCH_RESET = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [13:0] DAY_RESET = 14'h0000;

  // Two-second units in one day.
  localparam logic [15:0] TWO_SEC_PER_DAY = 16'ha8c0;

  // Shortest periodic interval in counter clock ticks (0.125 s).
  localparam logic [19:0] PERIOD_BASE_TICKS = 20'h01000;

  // Clock source switch must finish within this time.
  localparam int PCLK_HZ = 40_000_000;
  localparam int SWITCH_TIME_NS = 16_000;
  localparam int SWITCH_CYCLES = (SWITCH_TIME_NS / 1000) * (PCLK_HZ / 1_000_000);
  localparam logic [9:0] SWITCH_LIMIT = 10'(SWITCH_CYCLES - 1);

endpackage : rtt_pkg

`default_nettype wire

/* File: test/rtt_timer_trigger_properties.sv */
/* Concurrent checks for the real-time counter block: APB answer timing,
   error response, read data shape, sticky flags and slow clock outputs.
   Assumes it is bound to rtt_timer_trigger and sees only its ports. */
`default_nettype none

// ============================================================
// Checker
// ============================================================
module rtt_timer_trigger_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic crystal_power_on,
  input wire logic [1:0] crystal_drive_tuning,
  input wire logic periodic_event_flag,
  input wire logic match_event_flag
);
  // Everything here lives in the APB clock domain.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A transfer that completes at this edge, and whether it is a write.
  logic done;
  logic wr_done;
  logic bad_addr;
  assign done = psel && penable && pready;
  assign wr_done = done && pwrite;
  // Unaligned or past the last register; both must be refused.
  assign bad_addr = (paddr[1:0] != 2'h0) || (paddr > rtt_pkg::OFS_SLOWCLK);

  one_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not one cycle after access start");
  idle_quiet_a: assert property (!(psel && penable) |-> !pready)
    else $error("pready outside an access");
  rdata_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero while idle");
  addr_err_a: assert property (done |-> pslverr == bad_addr)
    else $error("error response does not follow address");
  day_high_zero_a: assert property (done && !pwrite &&
    paddr == rtt_pkg::OFS_DAY |-> prdata[31:14] == 18'h0)
    else $error("day word upper bits not zero");
  count_hi_zero_a: assert property (done && !pwrite &&
    (paddr == rtt_pkg::OFS_SUBTICK || paddr == rtt_pkg::OFS_TWO_SEC)
    |-> prdata[31:16] == 16'h0)
    else $error("count word upper half not zero");
  power_on_a: assert property (wr_done && paddr == rtt_pkg::OFS_SLOWCLK
    |=> crystal_power_on == $past(pwdata[0]))
    else $error("power on output does not follow write");
  tune_out_a: assert property (wr_done && paddr == rtt_pkg::OFS_SLOWCLK
    |=> crystal_drive_tuning == $past(pwdata[3:2]))
    else $error("tuning output does not follow write");
  match_sticky_a: assert property (match_event_flag &&
    !(wr_done && paddr == rtt_pkg::OFS_FLAG) |=> match_event_flag)
    else $error("match flag dropped without a clear");
  period_sticky_a: assert property (periodic_event_flag &&
    !(wr_done && paddr == rtt_pkg::OFS_FLAG) |=> periodic_event_flag)
    else $error("periodic flag dropped without a clear");

  // Main scenarios that the bench should reach.
  cover property (wr_done && paddr == rtt_pkg::OFS_MODE);
  cover property (done && pslverr);
  cover property ($rose(match_event_flag));
  cover property ($rose(periodic_event_flag));
endmodule : rtt_timer_trigger_checker

bind rtt_timer_trigger rtt_timer_trigger_checker u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .crystal_power_on(crystal_power_on),
  .crystal_drive_tuning(crystal_drive_tuning),
  .periodic_event_flag(periodic_event_flag),
  .match_event_flag(match_event_flag));

`default_nettype wire

/* File: test/testbench.sv */
/* Self-checking bench for the real-time counter block.
   Assumes the package and top module from rtl/; the bench is the APB
   master and makes both 32 kHz clock pins itself. */
`default_nettype none

// ============================================================
// Testbench
// ============================================================
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Short names for the register map.
  localparam logic [7:0] A_MAT = rtt_pkg::OFS_MATCH;
  localparam logic [7:0] A_SUB = rtt_pkg::OFS_SUBTICK;
  localparam logic [7:0] A_TWO = rtt_pkg::OFS_TWO_SEC;
  localparam logic [7:0] A_DAY = rtt_pkg::OFS_DAY;
  localparam logic [7:0] A_MOD = rtt_pkg::OFS_MODE;
  localparam logic [7:0] A_FLG = rtt_pkg::OFS_FLAG;
  localparam logic [7:0] A_SCK = rtt_pkg::OFS_SLOWCLK;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic osc = 1'b0;
  logic xtal = 1'b0;
  logic pon;
  logic [1:0] tune;
  logic pflag;
  logic mflag;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;

  rtt_timer_trigger dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_osc_clk(osc), .external_slow_crystal(xtal),
    .crystal_power_on(pon), .crystal_drive_tuning(tune),
    .periodic_event_flag(pflag), .match_event_flag(mflag));

  // 40 MHz bus clock.
  always #12.5 pclk = ~pclk;

  // Cuts a hang short; the whole run needs about 65000 cycles.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ============================================================
  // Shared tasks
  // ============================================================
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Software's relative target: now plus whole seconds of ticks, pushed
  // on by one two-second unit when the low half is not zero.
  function automatic logic [31:0] rel_target(input logic [31:0] now,
    input int secs);
    logic [31:0] t;
    t = now + 32'(secs) * 32'h0000_8000;
    if (t[15:0] != 16'h0000) begin
      t = t + 32'h0001_0000;
    end
    return t;
  endfunction : rel_target

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  // Reads a word and compares data and error response.
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
    input logic xe = 1'b0);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask : rd

  // Presets the lower counters through the match register.
  task automatic load(input logic [31:0] v, input logic [31:0] mode);
    wr(A_MAT, v);
    wr(A_MOD, mode | 32'h40);
  endtask : load

  // Counter clock pulses; each is held long enough for the synchroniser.
  task automatic tick(input int n, input logic ext = 1'b0);
    repeat (n) begin
      @(posedge pclk);
      if (ext) begin
        xtal <= 1'b1;
      end else begin
        osc <= 1'b1;
      end
      repeat (2) @(posedge pclk);
      if (ext) begin
        xtal <= 1'b0;
      end else begin
        osc <= 1'b0;
      end
      repeat (2) @(posedge pclk);
    end
    repeat (3) @(posedge pclk);
  endtask : tick

  // Looks at the flag pins once the last write has landed.
  task automatic flags(input logic m, input logic p);
    @(posedge pclk);
    chk({30'h0, mflag, pflag}, {30'h0, m, p});
  endtask : flags

  // ============================================================
  // Scenarios
  // ============================================================
  task automatic t_reset_map();
    rd(A_MAT, 32'h0);
    rd(A_MOD, 32'h02);
    rd(A_FLG, 32'h30);
    rd(A_SCK, 32'h04);
    wr(A_SUB, 32'hffff);
    rd(A_SUB, 32'h0);
    rd(8'h1c, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
  endtask : t_reset_map

  task automatic t_loads();
    wr(A_MAT, 32'h1234_5678);
    wr(A_MOD, 32'hc2);
    rd(A_MOD, 32'h02);
    rd(A_MAT, 32'h1234_5678);
    rd(A_DAY, 32'h1678);
    rd(A_TWO, 32'h1234);
    rd(A_SUB, 32'h5678);
    load(32'h0003_fffe, 32'h02);
    tick(2);
    rd(A_SUB, 32'h0);
    rd(A_TWO, 32'h4);
    load(32'ha8bf_ffff, 32'h02);
    tick(1);
    rd(A_TWO, 32'h0);
    rd(A_DAY, 32'h1679);
  endtask : t_loads

  task automatic t_match();
    load(32'h13, 32'h02);
    wr(A_MAT, 32'h14);
    tick(1);
    flags(1'b0, 1'b0);
    load(32'h13, 32'h22);
    wr(A_MAT, 32'h15);
    tick(1);
    flags(1'b0, 1'b0);
    tick(1);
    flags(1'b1, 1'b0);
    rd(A_FLG, 32'h90);
    wr(A_FLG, 32'h20);
    flags(1'b0, 1'b0);
    load(32'h13, 32'h2a);
    wr(A_MAT, 32'h15);
    tick(1);
    flags(1'b1, 1'b0);
    wr(A_FLG, 32'h20);
    wr(A_MOD, 32'h02);
    rd(A_FLG, 32'h30);
    // Target one second after a notional time, reached across a wrap.
    load(32'h0001_ffff, 32'h22);
    wr(A_MAT, rel_target(32'h0001_8000, 1));
    rd(A_MAT, 32'h0002_0000);
    tick(1);
    flags(1'b1, 1'b0);
    wr(A_FLG, 32'h20);
    wr(A_MOD, 32'h02);
  endtask : t_match

  task automatic t_periodic();
    wr(A_MOD, 32'h10);
    tick(4095);
    flags(1'b0, 1'b0);
    tick(1);
    flags(1'b0, 1'b1);
    rd(A_FLG, 32'h60);
    wr(A_FLG, 32'h10);
    flags(1'b0, 1'b0);
    wr(A_MOD, 32'h00);
    wr(A_MOD, 32'h11);
    tick(8191);
    flags(1'b0, 1'b0);
    tick(1);
    flags(1'b0, 1'b1);
    wr(A_MOD, 32'h01);
    wr(A_FLG, 32'h10);
    rd(A_FLG, 32'h70);
  endtask : t_periodic

  // Power the crystal, tune it, then switch and count on its edges.
  task automatic t_switch();
    wr(A_SCK, 32'h0d);
    @(posedge pclk);
    chk({29'h0, tune, pon}, 32'h7);
    wr(A_SCK, 32'h07);
    repeat (640) @(posedge pclk);
    rd(A_SCK, 32'h87);
    load(32'h0, 32'h00);
    tick(3, 1'b1);
    tick(2, 1'b0);
    rd(A_SUB, 32'h3);
    // Back to the internal oscillator with the crystal pin stuck high,
    // so only the time limit can complete the switch.
    xtal <= 1'b1;
    wr(A_SCK, 32'h05);
    repeat (640) @(posedge pclk);
    rd(A_SCK, 32'h05);
    xtal <= 1'b0;
  endtask : t_switch

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map();
    t_loads();
    t_match();
    t_periodic();
    t_switch();
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
